//--- acs_pkg.sv
`default_nettype none
package acs_pkg;
	// clock and measurement timing
	localparam int CLK_PERIOD_NS = 8;
	localparam longint CLK_HZ = 64'd1000000000 / CLK_PERIOD_NS;
	localparam int MEAS_WINDOW_US = 1000;
	localparam int MEAS_WINDOW_CYC = MEAS_WINDOW_US * 1000 / CLK_PERIOD_NS;

	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] RATES_OFS = 8'h08;
	localparam logic [7:0] FLASH_OFS = 8'h0c;

	// control field positions
	localparam int REC_BIT = 0;
	localparam int LOOP_BIT = 1;
	localparam int OPT2_AES_BIT = 2;
	localparam int AES_IN_OPT2_BIT = 3;
	localparam int AES_PRO_BIT = 4;
	localparam int WC_SINGLE_BIT = 5;
	localparam int BW_LSB = 6;
	localparam int RATE_LSB = 8;
	localparam int PREF_LSB = 12;
	localparam logic [31:0] CTRL_MASK = 32'h0000_7fff;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0200;

	// flash status field positions
	localparam int FLASH_FAIL_BIT = 0;
	localparam int FLASH_OK_BIT = 1;

	typedef enum logic [2:0] {
		SRC_INTERNAL = 3'h0,
		SRC_WORD = 3'h1,
		SRC_AES = 3'h2,
		SRC_OPT1 = 3'h3,
		SRC_OPT2 = 3'h4
	} clk_src_e;

	typedef enum logic [3:0] {
		R32 = 4'h0, R44 = 4'h1, R48 = 4'h2, R64 = 4'h3, R88 = 4'h4,
		R96 = 4'h5, R128 = 4'h6, R176 = 4'h7, R192 = 4'h8, R_NONE = 4'hf
	} rate_e;

	typedef enum logic [1:0] {
		IN_NOLOCK = 2'h0, IN_LOCK = 2'h1, IN_SYNC = 2'h2
	} in_state_e;

	typedef enum logic [1:0] {
		BW_ALL = 2'h0, BW_NO_OPT2 = 2'h1, BW_ANALOG_AES = 2'h2,
		BW_ANALOG8 = 2'h3
	} bw_e;

	typedef enum logic [1:0] {
		HOST_WAIT = 2'h0, HOST_USB = 2'h1, HOST_FW = 2'h2
	} host_e;

	typedef enum logic [1:0] {
		SPEED_SINGLE = 2'h0, SPEED_DOUBLE = 2'h1, SPEED_QUAD = 2'h2
	} speed_e;

	// isochronous channel counts per bandwidth setting
	localparam int ISO_CH = 30;
	localparam int NO_OPT2_CH = 22;
	localparam int ANALOG_AES_CH = 14;
	localparam int ANALOG8_CH = 8;
	localparam logic [29:0] ISO_ALL = 30'h3fff_ffff;

	// optical channels per speed
	localparam logic [3:0] OPT_CH_SINGLE = 4'h8;
	localparam logic [3:0] OPT_CH_DOUBLE = 4'h4;
	localparam logic [3:0] OPT_CH_QUAD = 4'h2;

	// nominal rates and edge-count bounds per measurement window
	localparam int RATE_HZ [0:8] = '{32000, 44100, 48000, 64000, 88200,
		96000, 128000, 176400, 192000};
	localparam logic [7:0] RATE_UPPER [0:8] = '{8'h26, 8'h2e, 8'h38,
		8'h4c, 8'h5c, 8'h70, 8'h98, 8'hb8, 8'hff};
	localparam logic [7:0] MIN_EDGES = 8'h10;

	typedef struct packed {
		logic usb_present;
		logic fw_present;
		logic xlr_aes_rx;
		logic opt2_rx;
		logic [3:0] lock;
		logic [3:0] phase;
		logic [3:0] frame;
	} pins_s;

	typedef struct packed {
		logic usb_active;
		logic fw_active;
		logic boot_secondary;
		logic rec_proc_input;
		logic rec_proc_output;
		logic opt2_tx;
		logic aes_rx;
		logic aes_professional;
		logic word_clock_out;
		clk_src_e clk_current;
		logic [29:0] iso_ch_enable;
		logic sample_multiplex_double;
		logic sample_multiplex_quad;
		logic [3:0] optical_channels;
	} out_s;

	// classify edges counted in one window
	function automatic rate_e classify(input logic [7:0] cnt);
		rate_e r;
		r = R_NONE;
		if (cnt >= MIN_EDGES)
		begin
			r = R192;
			for (int i = 8; i >= 0; i--)
				if (cnt < RATE_UPPER[i])
					r = rate_e'(4'(i));
		end
		return r;
	endfunction

	// phase step of the word clock oscillator
	function automatic logic [31:0] wc_inc(input rate_e r);
		logic [31:0] v;
		v = 32'h0;
		if (r <= R192)
			v = 32'((longint'(RATE_HZ[r]) << 32) / CLK_HZ);
		return v;
	endfunction
endpackage
`default_nettype wire

//--- audio_clock_source_select.sv
// Design decisions made here: the APB slave port and the placing of the registers.
`default_nettype none
module audio_clock_source_select #(
	parameter int MEAS_WINDOW = acs_pkg::MEAS_WINDOW_CYC
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire acs_pkg::pins_s pins,
	input  wire logic          aes_tx,
	input  wire logic          opt2_fmt_tx,
	output acs_pkg::out_s      status_out
);

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [31:0] ctrl;
		logic fw_fail;
		acs_pkg::host_e host;
		acs_pkg::pins_s s1;
		acs_pkg::pins_s s2;
		logic [3:0] frame_q;
		logic [16:0] win;
		logic [3:0][7:0] edges;
		acs_pkg::rate_e [3:0] rate;
		acs_pkg::in_state_e [3:0] in_st;
		logic [31:0] nco;
		acs_pkg::out_s out;
	} st_s;

	st_s q;
	st_s n;
	logic tick;
	logic access;
	logic wr_done;
	logic pref_ok;
	acs_pkg::clk_src_e pref;
	acs_pkg::clk_src_e cur;
	acs_pkg::rate_e rate_cfg;
	acs_pkg::rate_e wc_rate;
	acs_pkg::speed_e speed;
	logic [31:0] status_word;
	logic [31:0] rates_word;

	// next-state logic
	always_comb
	begin
		n = q;
		// two-stage synchronisers on all pin inputs
		n.s1 = pins;
		n.s2 = q.s1;
		n.frame_q = q.s2.frame;

		// measurement window
		tick = (q.win == 17'(MEAS_WINDOW - 1));
		n.win = tick ? 17'h0 : q.win + 17'h1;

		// host link chosen once after reset
		if (q.host == acs_pkg::HOST_WAIT && tick)
		begin
			if (q.s2.usb_present)
				n.host = acs_pkg::HOST_USB;
			else if (q.s2.fw_present)
				n.host = acs_pkg::HOST_FW;
		end
		n.out.usb_active = (n.host == acs_pkg::HOST_USB);
		n.out.fw_active = (n.host == acs_pkg::HOST_FW);

		// reference selection
		pref = acs_pkg::clk_src_e'(q.ctrl[acs_pkg::PREF_LSB +: 3]);
		pref_ok = pref != acs_pkg::SRC_INTERNAL
			&& pref <= acs_pkg::SRC_OPT2
			&& q.s2.lock[2'(pref - 3'h1)];
		cur = acs_pkg::SRC_INTERNAL;
		for (int i = 3; i >= 0; i--)
			if (q.s2.lock[i])
				cur = acs_pkg::clk_src_e'(3'(i + 1));
		if (pref == acs_pkg::SRC_INTERNAL)
			cur = acs_pkg::SRC_INTERNAL;
		else if (pref_ok)
			cur = pref;
		n.out.clk_current = cur;

		// per-input rate counting and status
		for (int i = 0; i < 4; i++)
		begin
			if (tick)
			begin
				n.rate[i] = q.s2.lock[i]
					? acs_pkg::classify(q.edges[i])
					: acs_pkg::R_NONE;
				n.edges[i] = 8'h0;
			end
			else if (q.s2.frame[i] && !q.frame_q[i]
				&& q.edges[i] != 8'hff)
				n.edges[i] = q.edges[i] + 8'h1;
			if (!q.s2.lock[i])
				n.in_st[i] = acs_pkg::IN_NOLOCK;
			else if (q.s2.phase[i])
				n.in_st[i] = acs_pkg::IN_SYNC;
			else
				n.in_st[i] = acs_pkg::IN_LOCK;
		end

		// rate, speed and word clock
		rate_cfg = acs_pkg::rate_e'(q.ctrl[acs_pkg::RATE_LSB +: 4]);
		if (rate_cfg <= acs_pkg::R48)
			speed = acs_pkg::SPEED_SINGLE;
		else if (rate_cfg <= acs_pkg::R96)
			speed = acs_pkg::SPEED_DOUBLE;
		else
			speed = acs_pkg::SPEED_QUAD;
		wc_rate = rate_cfg;
		if (q.ctrl[acs_pkg::WC_SINGLE_BIT] && rate_cfg > acs_pkg::R48
			&& rate_cfg <= acs_pkg::R192)
			wc_rate = acs_pkg::rate_e'(4'(rate_cfg % 4'h3));
		n.nco = q.nco + acs_pkg::wc_inc(wc_rate);
		n.out.word_clock_out = q.nco[31];
		n.out.sample_multiplex_double =
			(speed == acs_pkg::SPEED_DOUBLE);
		n.out.sample_multiplex_quad = (speed == acs_pkg::SPEED_QUAD);
		case (speed)
			acs_pkg::SPEED_SINGLE: n.out.optical_channels =
				acs_pkg::OPT_CH_SINGLE;
			acs_pkg::SPEED_DOUBLE: n.out.optical_channels =
				acs_pkg::OPT_CH_DOUBLE;
			default: n.out.optical_channels = acs_pkg::OPT_CH_QUAD;
		endcase

		// isochronous channel enables
		case (acs_pkg::bw_e'(q.ctrl[acs_pkg::BW_LSB +: 2]))
			acs_pkg::BW_ALL: n.out.iso_ch_enable = acs_pkg::ISO_ALL;
			acs_pkg::BW_NO_OPT2: n.out.iso_ch_enable = acs_pkg::ISO_ALL
				>> (acs_pkg::ISO_CH - acs_pkg::NO_OPT2_CH);
			acs_pkg::BW_ANALOG_AES: n.out.iso_ch_enable = acs_pkg::ISO_ALL
				>> (acs_pkg::ISO_CH - acs_pkg::ANALOG_AES_CH);
			default: n.out.iso_ch_enable = acs_pkg::ISO_ALL
				>> (acs_pkg::ISO_CH - acs_pkg::ANALOG8_CH);
		endcase

		// signal routing
		n.out.rec_proc_input = q.ctrl[acs_pkg::REC_BIT]
			&& !q.ctrl[acs_pkg::LOOP_BIT];
		n.out.rec_proc_output = q.ctrl[acs_pkg::REC_BIT]
			&& q.ctrl[acs_pkg::LOOP_BIT];
		n.out.opt2_tx = q.ctrl[acs_pkg::OPT2_AES_BIT]
			? aes_tx : opt2_fmt_tx;
		n.out.aes_rx = q.ctrl[acs_pkg::AES_IN_OPT2_BIT]
			? q.s2.opt2_rx : q.s2.xlr_aes_rx;
		n.out.aes_professional = q.ctrl[acs_pkg::AES_PRO_BIT];

		// status words
		status_word = {16'h0, 2'(speed), q.out.fw_active, q.fw_fail,
			q.out.usb_active, q.in_st, q.out.clk_current};
		rates_word = {16'h0, q.rate};

		// apb slave, answer one cycle into the access phase
		access = psel && penable;
		wr_done = access && q.pready && pwrite && !q.pslverr;
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		if (access && !q.pready)
		begin
			n.pready = 1'b1;
			case (paddr)
				acs_pkg::CTRL_OFS: n.prdata = q.ctrl;
				acs_pkg::STATUS_OFS: n.prdata = status_word;
				acs_pkg::RATES_OFS: n.prdata = rates_word;
				acs_pkg::FLASH_OFS: n.prdata = {31'h0, q.fw_fail};
				default:
				begin
					n.prdata = 32'h0;
					n.pslverr = 1'b1;
				end
			endcase
		end
		if (wr_done && paddr == acs_pkg::CTRL_OFS)
			n.ctrl = pwdata & acs_pkg::CTRL_MASK;
		if (wr_done && paddr == acs_pkg::FLASH_OFS)
		begin
			if (pwdata[acs_pkg::FLASH_OK_BIT])
				n.fw_fail = 1'b0;
			if (pwdata[acs_pkg::FLASH_FAIL_BIT])
				n.fw_fail = 1'b1;
		end
		n.out.boot_secondary = n.fw_fail;
	end

	// state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.ctrl <= acs_pkg::CTRL_RESET;
			q.out.iso_ch_enable <= acs_pkg::ISO_ALL;
			q.out.optical_channels <= acs_pkg::OPT_CH_SINGLE;
			for (int i = 0; i < 4; i++)
				q.rate[i] <= acs_pkg::R_NONE;
		end
		else
			q <= n;
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign status_out = q.out;

	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_one_host_link: assert property (
		!(q.out.usb_active && q.out.fw_active))
		else $error("both host links active");
	a_usb_first_pick: assert property (
		(q.host == acs_pkg::HOST_WAIT && tick && q.s2.usb_present)
		|=> q.out.usb_active && !q.out.fw_active)
		else $error("usb not preferred");
	a_flash_fail_boot: assert property (
		(wr_done && paddr == acs_pkg::FLASH_OFS
			&& pwdata[acs_pkg::FLASH_FAIL_BIT])
		|=> q.out.boot_secondary [*2])
		else $error("secondary image not selected");
	a_rec_path_split: assert property (
		(q.ctrl[acs_pkg::REC_BIT] && q.ctrl[acs_pkg::LOOP_BIT])
		|=> q.out.rec_proc_output && !q.out.rec_proc_input)
		else $error("record processing on wrong path");
	a_opt2_route: assert property (
		q.ctrl[acs_pkg::OPT2_AES_BIT] |=> q.out.opt2_tx == $past(aes_tx))
		else $error("optical two not fed from aes");
	a_aes_in_route: assert property (
		q.ctrl[acs_pkg::AES_IN_OPT2_BIT]
		|=> q.out.aes_rx == $past(q.s2.opt2_rx))
		else $error("aes input not from optical two");
	a_keep_preferred: assert property (
		pref_ok |=> q.out.clk_current == $past(pref))
		else $error("locked preferred input dropped");
	a_scan_word_first: assert property (
		(pref != acs_pkg::SRC_INTERNAL && !pref_ok && q.s2.lock[0])
		|=> q.out.clk_current == acs_pkg::SRC_WORD)
		else $error("fallback order wrong");
	a_internal_fallback: assert property (
		(q.s2.lock == 4'h0) |=> q.out.clk_current == acs_pkg::SRC_INTERNAL)
		else $error("no lock but external clock");
	a_sync_needs_lock: assert property (
		q.in_st[0] == acs_pkg::IN_SYNC |-> $past(q.s2.lock[0]))
		else $error("sync without lock");
	a_write_at_once: assert property (
		(wr_done && paddr == acs_pkg::CTRL_OFS)
		|=> q.ctrl == ($past(pwdata) & acs_pkg::CTRL_MASK))
		else $error("control write not applied");

	// host link choice and flash flag
	a_fw_when_alone: assert property (
		(q.host == acs_pkg::HOST_WAIT && tick && !q.s2.usb_present
			&& q.s2.fw_present) |=> q.out.fw_active && !q.out.usb_active)
		else $error("lone 1394 link not taken");
	a_host_frozen: assert property (
		(q.host != acs_pkg::HOST_WAIT) |=> q.host == $past(q.host))
		else $error("host link changed after choice");
	a_flash_ok_clear: assert property (
		(wr_done && paddr == acs_pkg::FLASH_OFS
			&& pwdata[acs_pkg::FLASH_OK_BIT]
			&& !pwdata[acs_pkg::FLASH_FAIL_BIT]) |=> !q.out.boot_secondary)
		else $error("success write left secondary image");

	// routing of processing and digital streams
	a_rec_input_path: assert property (
		(q.ctrl[acs_pkg::REC_BIT] && !q.ctrl[acs_pkg::LOOP_BIT])
		|=> q.out.rec_proc_input && !q.out.rec_proc_output)
		else $error("input processing not in record path");
	a_rec_off: assert property (
		!q.ctrl[acs_pkg::REC_BIT]
		|=> !q.out.rec_proc_input && !q.out.rec_proc_output)
		else $error("record processing on while off");
	a_opt2_native: assert property (
		!q.ctrl[acs_pkg::OPT2_AES_BIT] |=> q.out.opt2_tx == $past(opt2_fmt_tx))
		else $error("optical two not fed multichannel");
	a_aes_in_xlr: assert property (
		!q.ctrl[acs_pkg::AES_IN_OPT2_BIT]
		|=> q.out.aes_rx == $past(q.s2.xlr_aes_rx))
		else $error("aes input not from xlr");
	a_aes_status_fmt: assert property (
		1'b1 |=> q.out.aes_professional == $past(q.ctrl[acs_pkg::AES_PRO_BIT]))
		else $error("channel status format wrong");

	// channel bandwidth and speed
	a_iso_all_default: assert property (
		(q.ctrl[acs_pkg::BW_LSB +: 2] == 2'h0)
		|=> q.out.iso_ch_enable == acs_pkg::ISO_ALL)
		else $error("not all channels enabled");
	a_iso_no_opt2: assert property (
		(q.ctrl[acs_pkg::BW_LSB +: 2] == 2'h1)
		|=> q.out.iso_ch_enable[29:22] == 8'h0 && &q.out.iso_ch_enable[21:0])
		else $error("channels 23 to 30 not dropped");
	a_iso_analog_aes: assert property (
		(q.ctrl[acs_pkg::BW_LSB +: 2] == 2'h2)
		|=> q.out.iso_ch_enable[29:14] == 16'h0 && &q.out.iso_ch_enable[13:0])
		else $error("analog and aes set wrong");
	a_iso_analog8: assert property (
		(q.ctrl[acs_pkg::BW_LSB +: 2] == 2'h3)
		|=> q.out.iso_ch_enable == 30'h0000_00ff)
		else $error("first eight channels set wrong");
	a_single_speed: assert property (
		(rate_cfg <= acs_pkg::R48) |=> !q.out.sample_multiplex_double
			&& q.out.optical_channels == acs_pkg::OPT_CH_SINGLE)
		else $error("single speed flags wrong");
	a_double_speed: assert property (
		(rate_cfg == acs_pkg::R88 || rate_cfg == acs_pkg::R96)
		|=> q.out.sample_multiplex_double
			&& q.out.optical_channels == acs_pkg::OPT_CH_DOUBLE)
		else $error("double speed flags wrong");
	a_quad_speed: assert property (
		(rate_cfg == acs_pkg::R176 || rate_cfg == acs_pkg::R192)
		|=> q.out.sample_multiplex_quad
			&& q.out.optical_channels == acs_pkg::OPT_CH_QUAD)
		else $error("quad speed flags wrong");

	// input status and reference
	a_nolock_state: assert property (
		!q.s2.lock[1] |=> q.in_st[1] == acs_pkg::IN_NOLOCK)
		else $error("unlocked input not reported");
	a_lock_no_phase: assert property (
		(q.s2.lock[2] && !q.s2.phase[2]) |=> q.in_st[2] == acs_pkg::IN_LOCK)
		else $error("locked input state wrong");
	a_rate_unlocked: assert property (
		(tick && !q.s2.lock[3]) |=> q.rate[3] == acs_pkg::R_NONE)
		else $error("rate shown without lock");
	a_internal_pref: assert property (
		(pref == acs_pkg::SRC_INTERNAL)
		|=> q.out.clk_current == acs_pkg::SRC_INTERNAL)
		else $error("master mode not internal");

	c_usb_chosen: cover property (q.out.usb_active);
	c_fw_chosen: cover property (q.out.fw_active);
	c_fall_to_opt2: cover property (
		q.out.clk_current == acs_pkg::SRC_OPT2 && pref != acs_pkg::SRC_OPT2);
	c_input_sync: cover property (q.in_st[3] == acs_pkg::IN_SYNC);

endmodule // audio_clock_source_select
`default_nettype wire

//--- far_end_model.sv
`default_nettype none
// external gear: frame clocks, lock and phase pins, cable presence
module far_end_model (
	input  wire logic      pclk,
	input  wire logic [3:0] lock_cfg,
	input  wire logic [3:0] phase_cfg,
	input  wire logic [3:0] src_cfg,
	output acs_pkg::pins_s pins
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER [4] = '{5, 4, 6, 3};
	int         cnt [4] = '{0, 0, 0, 0};
	logic [3:0] fr = 4'h0;
	// free running frame clocks, one period per input
	always @(posedge pclk)
		for (int i = 0; i < 4; i++)
		begin
			cnt[i] <= (cnt[i] + 1) % PER[i];
			fr[i] <= (cnt[i] < PER[i] / 2);
		end
	// cable and serial sources, lock, phase and frame lines
	assign pins = acs_pkg::pins_s'({src_cfg, lock_cfg, phase_cfg, fr});
endmodule // far_end_model
`default_nettype wire

//--- tb_audio_clock_source_select.sv
`default_nettype none
module tb_audio_clock_source_select;
	timeunit 1ns;
	timeprecision 1ps;
	logic           pclk = 1'b0;
	logic           presetn = 1'b0;
	logic           psel = 1'b0;
	logic           penable = 1'b0;
	logic           pwrite = 1'b0;
	logic [7:0]     paddr = 8'h00;
	logic [31:0]    pwdata = 32'h0;
	logic [31:0]    prdata;
	logic           pready;
	logic           pslverr;
	logic           aes_tx = 1'b0;
	logic           opt2_fmt_tx = 1'b0;
	logic [3:0]     lock_cfg = 4'hf;
	logic [3:0]     phase_cfg = 4'h0;
	logic [3:0]     src_cfg = 4'hc;
	acs_pkg::pins_s pins;
	acs_pkg::out_s  so;
	int             n_errors = 0;
	int             n_checks = 0;
	int             rq [$] = '{0, 1, 2, 4, 5, 7, 8};

	audio_clock_source_select #(.MEAS_WINDOW(200)) i_audio_clock_source_select (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pins(pins), .aes_tx(aes_tx),
		.opt2_fmt_tx(opt2_fmt_tx), .status_out(so));
	far_end_model i_far_end_model (.pclk(pclk), .lock_cfg(lock_cfg),
		.phase_cfg(phase_cfg), .src_cfg(src_cfg), .pins(pins));

	// 125 MHz clock
	initial
	begin
		forever #4 pclk = ~pclk;
	end

	task automatic close_out();
		$display("checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// word clock period in cycles against the rate in hz
	task automatic wc_chk(input int hz);
		int c;
		int e;
		c = 0;
		e = 125000000 / hz;
		while (so.word_clock_out !== 1'b0) @(posedge pclk);
		while (so.word_clock_out !== 1'b1) @(posedge pclk);
		do
		begin
			@(posedge pclk);
			c++;
		end
		while (so.word_clock_out === 1'b1);
		while (so.word_clock_out !== 1'b1)
		begin
			@(posedge pclk);
			c++;
		end
		chk(32'(c >= e - 2 && c <= e + 2), 32'h1);
	endtask

	// reference the bench expects for a preference and lock set
	function automatic int exp_clk(int pref, logic [3:0] lk);
		if (pref == 0)
			return 0;
		if (pref <= 4 && lk[pref - 1])
			return pref;
		for (int i = 0; i < 4; i++)
			if (lk[i])
				return i + 1;
		return 0;
	endfunction

	// hang guard
	initial
	begin
		#640000;
		n_errors++;
		close_out();
	end

	// main sequence
	initial
	begin
		logic [31:0] r;
		logic [31:0] w;
		logic        e;
		int          ec;
		int          st;
		int          sp;
		int          nb;
		void'($urandom(32'h2aab6add));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, acs_pkg::CTRL_OFS, 32'h0, r, e);
		chk(r, acs_pkg::CTRL_RESET);
		chk(32'(so.iso_ch_enable), 32'(acs_pkg::ISO_ALL));
		chk(32'(so.optical_channels), 32'h8);
		repeat (500) @(posedge pclk);
		chk(32'({so.usb_active, so.fw_active}), 32'h2);
		apb(1'b0, acs_pkg::RATES_OFS, 32'h0, r, e);
		chk(r, 32'h0000_3021);
		$display("reset, host and rate tests done");
		wc_chk(48000);
		apb(1'b1, acs_pkg::CTRL_OFS, 32'h0000_0500, r, e);
		wc_chk(96000);
		apb(1'b1, acs_pkg::CTRL_OFS, 32'h0000_0520, r, e);
		wc_chk(48000);
		apb(1'b1, acs_pkg::CTRL_OFS, 32'h0000_0820, r, e);
		wc_chk(48000);
		$display("word clock tests done");
		for (int k = 0; k < 16; k++)
		begin
			w = $urandom & acs_pkg::CTRL_MASK;
			w[11:8] = 4'(rq[$urandom % 7]);
			lock_cfg <= 4'($urandom);
			phase_cfg <= 4'($urandom);
			src_cfg[1:0] <= 2'($urandom);
			aes_tx <= 1'($urandom);
			opt2_fmt_tx <= 1'($urandom);
			apb(1'b1, acs_pkg::CTRL_OFS, w, r, e);
			repeat (6) @(posedge pclk);
			ec = exp_clk(int'(w[14:12]), lock_cfg);
			st = 0;
			for (int i = 0; i < 4; i++)
				st |= (lock_cfg[i] ? (phase_cfg[i] ? 2 : 1) : 0) << (2 * i);
			sp = (w[11:8] == 4 || w[11:8] == 5) ? 1 : (w[11:8] >= 7 ? 2 : 0);
			nb = w[7:6] == 0 ? 30 : w[7:6] == 1 ? 22 : w[7:6] == 2 ? 14 : 8;
			chk(32'(so.clk_current), 32'(ec));
			chk(32'(so.iso_ch_enable), 32'((64'd1 << nb) - 1));
			chk(32'({so.sample_multiplex_quad, so.sample_multiplex_double}),
				32'(sp));
			chk(32'(so.optical_channels), sp == 0 ? 32'h8 : 32'(8 >> sp));
			chk(32'({so.aes_professional, so.aes_rx, so.opt2_tx,
				so.rec_proc_output, so.rec_proc_input}),
				32'({w[4], w[3] ? src_cfg[0] : src_cfg[1],
				w[2] ? aes_tx : opt2_fmt_tx, w[0] & w[1], w[0] & ~w[1]}));
			apb(1'b0, acs_pkg::STATUS_OFS, 32'h0, r, e);
			chk(32'(r[2:0]), 32'(ec));
			chk(32'(r[10:3]), 32'(st));
			chk(32'({r[15:14], r[13], r[11]}), 32'((sp << 2) | 1));
			apb(1'b0, acs_pkg::CTRL_OFS, 32'h0, r, e);
			chk(r, w);
		end
		$display("configuration and clock selection tests done");
		apb(1'b1, acs_pkg::FLASH_OFS, 32'h1, r, e);
		@(posedge pclk);
		chk(32'(so.boot_secondary), 32'h1);
		apb(1'b0, acs_pkg::STATUS_OFS, 32'h0, r, e);
		chk(32'(r[12]), 32'h1);
		apb(1'b1, acs_pkg::FLASH_OFS, 32'h2, r, e);
		@(posedge pclk);
		chk(32'(so.boot_secondary), 32'h0);
		apb(1'b1, acs_pkg::FLASH_OFS, 32'h3, r, e);
		apb(1'b0, acs_pkg::FLASH_OFS, 32'h0, r, e);
		chk(32'(r[0]), 32'h1);
		$display("boot image tests done");
		apb(1'b0, 8'h10, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1);
		apb(1'b1, 8'h01, 32'h0000_7fff, r, e);
		chk(32'(e), 32'h1);
		apb(1'b0, acs_pkg::CTRL_OFS, 32'h0, r, e);
		chk(r, w);
		$display("unmapped access tests done");
		close_out();
	end
endmodule // tb_audio_clock_source_select
`default_nettype wire
